/* File: src/fuc_consts.svh */
// Constants of the serial unit
`ifndef FUC_CONSTS_SVH
`define FUC_CONSTS_SVH

// Word indices, byte address = index * 4
`define FUC_IDX_CTRL 3'h0
`define FUC_IDX_STAT 3'h1
`define FUC_IDX_TXDATA 3'h2
`define FUC_IDX_RXDATA 3'h3
`define FUC_IDX_FIFOCTL 3'h4
`define FUC_IDX_BAUD 3'h5

// serial_control fields
`define FUC_CTRL_TIE 7
`define FUC_CTRL_RIE 6
`define FUC_CTRL_TE 5
`define FUC_CTRL_RE 4
`define FUC_CTRL_CKE_HI 1
`define FUC_CTRL_CKE_LO 0
`define FUC_CTRL_RST 6'h00

// serial_status fields
`define FUC_STAT_ER 7
`define FUC_STAT_TX_FIFO_LOW_FLAG 5
`define FUC_STAT_BRK 4
`define FUC_STAT_FER 3
`define FUC_STAT_PER 2
`define FUC_STAT_RDF 1
`define FUC_STAT_DR 0
`define FUC_FLAGS_RST 7'h20

// fifo_control fields
`define FUC_FCR_TXTRIG_LO 0
`define FUC_FCR_RXTRIG_LO 8
`define FUC_FCR_RXFLUSH 16
`define FUC_FCR_TXFLUSH 17
`define FUC_TXTRIG_RST 6'h08
`define FUC_RXTRIG_RST 6'h01

// Baud and oversampling
`define FUC_BAUD_RST 8'h00
`define FUC_OVS_LAST 4'hF
`define FUC_OVS_MID 4'h7
`define FUC_BIT_LAST 3'h7

`endif

/* File: src/fuc_pkg.sv */
// Serial unit types
package fuc_pkg;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_DATA = 2'b10,
        RX_STOP = 2'b11
    } fucRxState_t;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_START = 2'b01,
        TX_DATA = 2'b10,
        TX_STOP = 2'b11
    } fucTxState_t;

    typedef struct packed {
        logic txIntEnable;
        logic rxIntEnable;
        logic transmitterOn;
        logic rxEnable;
        logic [1:0] clockEnable;
    } fucCtrl_t;

    typedef struct packed {
        logic rxFault;
        logic txFifoLow;
        logic lineBreak;
        logic framingFault;
        logic parityFault;
        logic rxFifoFull;
        logic rxDataReady;
    } fucFlags_t;

endpackage

/* File: src/fuc_fifo.sv */
// Flip-flop FIFO with flush
`timescale 1ns/1ps
`default_nettype none

module fuc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32,
    parameter int CW = $clog2(DEPTH + 1)
) (
    input wire logic clk, // System clock
    input wire logic reset_n, // Async reset, active low
    input wire logic flush, // Empty the queue
    input wire logic inValid, // Write side offers a word
    output logic inReady, // Room for a word
    input wire logic [WIDTH-1:0] inData, // Word to store
    output logic outValid, // A word is waiting
    input wire logic outReady, // Read side takes the word
    output logic [WIDTH-1:0] outData, // Oldest word
    output logic [CW-1:0] count // Words held
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_reg;
    logic [AW-1:0] rdPtr_reg;
    logic [CW-1:0] count_reg;
    logic doPush;
    logic doPop;

    assign inReady = (count_reg != CW'(DEPTH));
    assign outValid = (count_reg != '0);
    assign doPush = inValid & inReady;
    assign doPop = outReady & outValid;
    assign outData = mem[rdPtr_reg];
    assign count = count_reg;

    function automatic logic [AW-1:0] fucWrap(input logic [AW-1:0] p);
        fucWrap = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
    endfunction

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
        end else if (flush) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (doPush) begin
                wrPtr_reg <= fucWrap(wrPtr_reg);
            end
            if (doPop) begin
                rdPtr_reg <= fucWrap(rdPtr_reg);
            end
            if (doPush && !doPop) begin
                count_reg <= CW'(count_reg + 1'b1);
            end else if (doPop && !doPush) begin
                count_reg <= CW'(count_reg - 1'b1);
            end
        end
    end

    // Storage needs no reset; empty slots are never shown as valid
    always_ff @(posedge clk) begin
        if (doPush && !flush) begin
            mem[wrPtr_reg] <= inData;
        end
    end

endmodule

`default_nettype wire

/* File: src/fuc_uart.sv */
// Asynchronous serial unit with control enables, FIFOs and request lines
// Operation
// - Transmit enable gates FIFO-low request
// - FIFO-low request ends by refill-clear or disable
// - Receive enable gates level and fault requests
// - Receive enable low blocks all receive requests
// - Receive requests end by read-clear or disable
// - Bit 5 switches transmitter, resets off
// - Transmit waits for a queued character
// - Bit 4 switches receiver, resets off
// - Receiver off keeps receive flags unchanged
// - Reception begins only on start bit
// - Control always accessible, enables reset zero
`timescale 1ns/1ps
`default_nettype none
`include "fuc_consts.svh"

module fuc_uart #(
    parameter int DEPTH = 32,
    parameter int CW = $clog2(DEPTH + 1)
) (
    input wire logic clk, // 10 MHz system clock
    input wire logic reset_n, // Async reset, active low
    input wire logic [4:0] address, // Avalon byte address
    input wire logic read, // Avalon read
    input wire logic write, // Avalon write
    input wire logic [31:0] writedata, // Avalon write data
    input wire logic [3:0] byteenable, // Avalon byte lanes
    output var logic [31:0] readdata, // Avalon read data
    output logic waitrequest, // Avalon wait
    input wire logic rxd, // Serial receive line
    output var logic txd, // Serial transmit line
    output logic tx_space_irq, // Transmit FIFO low request
    output logic rx_level_irq, // Receive data ready or FIFO full request
    output logic rx_fault_irq, // Receive error request
    output logic line_break_irq // Line break request
);

    ////////////////////////////////////////////////////////////////////////
    // Registers and wires

    fuc_pkg::fucCtrl_t ctrl_reg;
    fuc_pkg::fucFlags_t flags_reg;
    fuc_pkg::fucFlags_t armed_reg;
    fuc_pkg::fucFlags_t wrZero;
    logic [CW-1:0] txTrig_reg;
    logic [CW-1:0] rxTrig_reg;
    logic [7:0] baudDiv_reg;
    logic [7:0] divCnt_reg;
    logic ack_reg;
    logic txFlush_reg;
    logic rxFlush_reg;
    logic [2:0] idx;
    logic accept;
    logic txStall;
    logic statWrite;
    logic ovsTick;

    logic txPush;
    logic txInReady;
    logic txOutValid;
    logic [7:0] txOutData;
    logic [CW-1:0] txCount;
    logic txPop;

    logic rxPush;
    logic rxPop;
    logic rxInReady;
    logic rxOutValid;
    logic [7:0] rxOutData;
    logic [CW-1:0] rxCount;
    logic rxDone;
    logic rxBad;

    fuc_pkg::fucRxState_t rxState_reg;
    logic [3:0] rxSub_reg;
    logic [2:0] rxBit_reg;
    logic [7:0] rxShift_reg;
    fuc_pkg::fucTxState_t txState_reg;
    logic [3:0] txSub_reg;
    logic [2:0] txBit_reg;
    logic [7:0] txShift_reg;

    // Merge write data into a register under the byte enables
    function automatic logic [31:0] fucMerge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0] be);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                m[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        fucMerge = m;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Avalon slave: one wait cycle, longer while the transmit FIFO is full

    assign idx = address[4:2];
    assign txStall = write & (idx == `FUC_IDX_TXDATA) & ~txInReady;
    assign waitrequest = (read | write) & ~ack_reg;
    assign accept = (read | write) & ack_reg;
    assign statWrite = accept & write & (idx == `FUC_IDX_STAT) & byteenable[0];
    assign txPush = accept & write & (idx == `FUC_IDX_TXDATA) & byteenable[0];
    assign rxPop = accept & read & (idx == `FUC_IDX_RXDATA) & rxOutValid;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (read | write) & ~ack_reg & ~txStall;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            readdata <= 32'h0000_0000;
        end else if (read && !ack_reg) begin
            readdata <= 32'h0000_0000;
            case (idx)
                `FUC_IDX_CTRL: readdata[7:0] <= {ctrl_reg[5:2], 2'b00,
                                                  ctrl_reg[1:0]};
                `FUC_IDX_STAT: readdata[7:0] <= {flags_reg[6], 1'b0,
                                                  flags_reg[5:0]};
                `FUC_IDX_RXDATA: readdata[7:0] <= rxOutValid ? rxOutData
                                                             : 8'h00;
                `FUC_IDX_FIFOCTL: begin
                    readdata[`FUC_FCR_TXTRIG_LO +: CW] <= txTrig_reg;
                    readdata[`FUC_FCR_RXTRIG_LO +: CW] <= rxTrig_reg;
                end
                `FUC_IDX_BAUD: readdata[7:0] <= baudDiv_reg;
                default: readdata <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control, FIFO control and baud registers

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_reg <= `FUC_CTRL_RST;
        end else if (accept && write && (idx == `FUC_IDX_CTRL) &&
                     byteenable[0]) begin
            ctrl_reg.txIntEnable <= writedata[`FUC_CTRL_TIE];
            ctrl_reg.rxIntEnable <= writedata[`FUC_CTRL_RIE];
            ctrl_reg.transmitterOn <= writedata[`FUC_CTRL_TE];
            ctrl_reg.rxEnable <= writedata[`FUC_CTRL_RE];
            ctrl_reg.clockEnable <=
                writedata[`FUC_CTRL_CKE_HI:`FUC_CTRL_CKE_LO];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            txTrig_reg <= `FUC_TXTRIG_RST;
            rxTrig_reg <= `FUC_RXTRIG_RST;
            baudDiv_reg <= `FUC_BAUD_RST;
            txFlush_reg <= 1'b0;
            rxFlush_reg <= 1'b0;
        end else begin
            txFlush_reg <= 1'b0;
            rxFlush_reg <= 1'b0;
            if (accept && write && (idx == `FUC_IDX_FIFOCTL)) begin
                txTrig_reg <= fucMerge(32'h0000_0000 | txTrig_reg, writedata,
                                       byteenable)[`FUC_FCR_TXTRIG_LO +: CW];
                rxTrig_reg <= fucMerge({16'h0000, 2'b00, rxTrig_reg, 8'h00},
                                       writedata,
                                       byteenable)[`FUC_FCR_RXTRIG_LO +: CW];
                txFlush_reg <= byteenable[2] & writedata[`FUC_FCR_TXFLUSH];
                rxFlush_reg <= byteenable[2] & writedata[`FUC_FCR_RXFLUSH];
            end
            if (accept && write && (idx == `FUC_IDX_BAUD) && byteenable[0]) begin
                baudDiv_reg <= writedata[7:0];
            end
        end
    end

    // Oversampling tick, 16 per bit
    assign ovsTick = (divCnt_reg == baudDiv_reg);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            divCnt_reg <= 8'h00;
        end else if (ovsTick) begin
            divCnt_reg <= 8'h00;
        end else begin
            divCnt_reg <= 8'(divCnt_reg + 8'h01);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status flags: read as 1 arms a clear, a 0 written then clears

    assign wrZero = ~writedata[6:0] & {7{statWrite}} & armed_reg;
    assign rxBad = rxDone & ~rxd;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            armed_reg <= '0;
        end else if (accept && read && (idx == `FUC_IDX_STAT)) begin
            armed_reg <= flags_reg;
        end else if (statWrite) begin
            armed_reg <= armed_reg & ~wrZero;
        end
    end

    // A set in the same cycle as a clear always wins
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            flags_reg <= `FUC_FLAGS_RST;
        end else begin
            // Low flag rises when a pop leaves fewer than trigger words
            if (txPop && (txCount <= txTrig_reg)) begin
                flags_reg.txFifoLow <= 1'b1;
            end else if (wrZero.txFifoLow && (txCount > txTrig_reg)) begin
                flags_reg.txFifoLow <= 1'b0;
            end
            if (rxCount >= rxTrig_reg) begin
                flags_reg.rxFifoFull <= 1'b1;
            end else if (wrZero.rxFifoFull) begin
                flags_reg.rxFifoFull <= 1'b0;
            end
            if (rxPush && (({1'b0, rxCount} + 1'b1) < {1'b0, rxTrig_reg})) begin
                flags_reg.rxDataReady <= 1'b1;
            end else if (wrZero.rxDataReady) begin
                flags_reg.rxDataReady <= 1'b0;
            end
            // Overrun counts as a reception error
            if (rxBad || (rxDone && !rxInReady)) begin
                flags_reg.rxFault <= 1'b1;
            end else if (wrZero.rxFault) begin
                flags_reg.rxFault <= 1'b0;
            end
            if (rxBad && (rxShift_reg == 8'h00)) begin
                flags_reg.lineBreak <= 1'b1;
            end else if (wrZero.lineBreak) begin
                flags_reg.lineBreak <= 1'b0;
            end
            // Framing flag follows the last character; never touched by RE
            if (rxDone) begin
                flags_reg.framingFault <= ~rxd;
            end
            flags_reg.parityFault <= 1'b0;
        end
    end

    // Plain gates: each request drops with its enable or its flag
    assign tx_space_irq = ctrl_reg.txIntEnable &
                          flags_reg.txFifoLow;
    assign rx_level_irq = ctrl_reg.rxIntEnable &
                          (flags_reg.rxFifoFull |
                           flags_reg.rxDataReady);
    assign rx_fault_irq = ctrl_reg.rxIntEnable &
                          flags_reg.rxFault;
    assign line_break_irq = ctrl_reg.rxIntEnable &
                            flags_reg.lineBreak;

    ////////////////////////////////////////////////////////////////////////
    // FIFOs

    fuc_fifo #(.WIDTH(8), .DEPTH(DEPTH), .CW(CW)) txQueue (
        .clk(clk),
        .reset_n(reset_n),
        .flush(txFlush_reg),
        .inValid(txPush),
        .inReady(txInReady),
        .inData(writedata[7:0]),
        .outValid(txOutValid),
        .outReady(txPop),
        .outData(txOutData),
        .count(txCount)
    );

    fuc_fifo #(.WIDTH(8), .DEPTH(DEPTH), .CW(CW)) rxQueue (
        .clk(clk),
        .reset_n(reset_n),
        .flush(rxFlush_reg),
        .inValid(rxPush),
        .inReady(rxInReady),
        .inData(rxShift_reg),
        .outValid(rxOutValid),
        .outReady(rxPop),
        .outData(rxOutData),
        .count(rxCount)
    );

    ////////////////////////////////////////////////////////////////////////
    // Transmitter, 8 data bits, one stop bit

    assign txPop = (txState_reg == fuc_pkg::TX_IDLE) &
                   ctrl_reg.transmitterOn & txOutValid;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            txState_reg <= fuc_pkg::TX_IDLE;
            txSub_reg <= 4'h0;
            txBit_reg <= 3'h0;
            txShift_reg <= 8'h00;
            txd <= 1'b1;
        end else if (!ctrl_reg.transmitterOn) begin
            txState_reg <= fuc_pkg::TX_IDLE;
            txd <= 1'b1;
        end else begin
            case (txState_reg)
                fuc_pkg::TX_IDLE: begin
                    if (txPop) begin
                        txShift_reg <= txOutData;
                        txState_reg <= fuc_pkg::TX_START;
                        txSub_reg <= 4'h0;
                        txBit_reg <= 3'h0;
                        txd <= 1'b0;
                    end
                end
                fuc_pkg::TX_START: begin
                    if (ovsTick) begin
                        txSub_reg <= 4'(txSub_reg + 4'h1);
                        if (txSub_reg == `FUC_OVS_LAST) begin
                            txState_reg <= fuc_pkg::TX_DATA;
                            txd <= txShift_reg[0];
                        end
                    end
                end
                fuc_pkg::TX_DATA: begin
                    if (ovsTick) begin
                        txSub_reg <= 4'(txSub_reg + 4'h1);
                        if (txSub_reg == `FUC_OVS_LAST) begin
                            txBit_reg <= 3'(txBit_reg + 3'h1);
                            if (txBit_reg == `FUC_BIT_LAST) begin
                                txState_reg <= fuc_pkg::TX_STOP;
                                txd <= 1'b1;
                            end else begin
                                txd <= txShift_reg[3'(txBit_reg + 3'h1)];
                            end
                        end
                    end
                end
                fuc_pkg::TX_STOP: begin
                    if (ovsTick) begin
                        txSub_reg <= 4'(txSub_reg + 4'h1);
                        if (txSub_reg == `FUC_OVS_LAST) begin
                            txState_reg <= fuc_pkg::TX_IDLE;
                        end
                    end
                end
                default: txState_reg <= fuc_pkg::TX_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receiver, samples at mid-bit; a full FIFO drops the character

    assign rxDone = (rxState_reg == fuc_pkg::RX_STOP) & ctrl_reg.rxEnable &
                    ovsTick & (rxSub_reg == `FUC_OVS_LAST);
    assign rxPush = rxDone & rxInReady;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rxState_reg <= fuc_pkg::RX_IDLE;
            rxSub_reg <= 4'h0;
            rxBit_reg <= 3'h0;
            rxShift_reg <= 8'h00;
        end else if (!ctrl_reg.rxEnable) begin
            rxState_reg <= fuc_pkg::RX_IDLE;
        end else begin
            case (rxState_reg)
                fuc_pkg::RX_IDLE: begin
                    if (!rxd) begin
                        rxState_reg <= fuc_pkg::RX_START;
                        rxSub_reg <= 4'h0;
                    end
                end
                fuc_pkg::RX_START: begin
                    if (ovsTick) begin
                        rxSub_reg <= 4'(rxSub_reg + 4'h1);
                        // Glitch shorter than half a bit is no start bit
                        if (rxSub_reg == `FUC_OVS_MID) begin
                            rxSub_reg <= 4'h0;
                            rxBit_reg <= 3'h0;
                            rxState_reg <= rxd ? fuc_pkg::RX_IDLE
                                               : fuc_pkg::RX_DATA;
                        end
                    end
                end
                fuc_pkg::RX_DATA: begin
                    if (ovsTick) begin
                        rxSub_reg <= 4'(rxSub_reg + 4'h1);
                        if (rxSub_reg == `FUC_OVS_LAST) begin
                            rxShift_reg <= {rxd, rxShift_reg[7:1]};
                            rxBit_reg <= 3'(rxBit_reg + 3'h1);
                            if (rxBit_reg == `FUC_BIT_LAST) begin
                                rxState_reg <= fuc_pkg::RX_STOP;
                            end
                        end
                    end
                end
                fuc_pkg::RX_STOP: begin
                    if (ovsTick) begin
                        rxSub_reg <= 4'(rxSub_reg + 4'h1);
                        if (rxSub_reg == `FUC_OVS_LAST) begin
                            rxState_reg <= fuc_pkg::RX_IDLE;
                        end
                    end
                end
                default: rxState_reg <= fuc_pkg::RX_IDLE;
            endcase
        end
    end

endmodule

`default_nettype wire

/* File: verification/fuc_uart_checker.sv */
// Port-level assertions for the serial unit
`timescale 1ns/1ps
`default_nettype none
module fuc_uart_checker (
    input wire logic clk, // Clock
    input wire logic reset_n, // Reset
    input wire logic [4:0] address, // Address
    input wire logic read, // Read
    input wire logic write, // Write
    input wire logic [31:0] writedata, // Wdata
    input wire logic [3:0] byteenable, // Lanes
    input wire logic [31:0] readdata, // Rdata
    input wire logic waitrequest, // Wait
    input wire logic rxd, // Rx line
    input wire logic txd, // Tx line
    input wire logic tx_space_irq, // Tx req
    input wire logic rx_level_irq, // Rx req
    input wire logic rx_fault_irq, // Fault req
    input wire logic line_break_irq // Break req
);
    ////////////////////////////////////////
    logic acc;
    logic wrCtrl;
    logic [7:0] ctrl_reg;
    assign acc = (read | write) & ~waitrequest;
    assign wrCtrl = acc & write & (address[4:2] == 3'h0) & byteenable[0];
    // Shadow of control taken from the bus, reserved bits read zero
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_reg <= 8'h00;
        end else if (wrCtrl) begin
            ctrl_reg <= writedata[7:0] & 8'hF3;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_wait_first: assert property ($rose(read | write) |-> waitrequest)
        else $error("request answered without wait");
    a_read_answer: assert property ($rose(read) |-> ##1 !waitrequest)
        else $error("read not answered");
    a_idle_quiet: assert property (!(read | write) |-> !waitrequest)
        else $error("wait without request");
    a_ctrl_readback: assert property ((read && !waitrequest
        && address[4:2] == 3'h0) |-> readdata[7:0] == ctrl_reg)
        else $error("control readback wrong");
    a_unmapped_zero: assert property ((read && !waitrequest
        && address[4:2] > 3'h5) |-> readdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_tx_gate: assert property (!ctrl_reg[7] |-> !tx_space_irq)
        else $error("tx request while disabled");
    a_rx_gate: assert property (!ctrl_reg[6] |->
        !(rx_level_irq | rx_fault_irq | line_break_irq))
        else $error("rx request while disabled");
    a_tx_off_idle: assert property ((!ctrl_reg[5] &&
        !$past(ctrl_reg[5])) |-> txd)
        else $error("txd active while off");
    a_flags_hold: assert property ((!ctrl_reg[4] && !$past(ctrl_reg[4])
        && !$past(acc & write)) |-> $stable({rx_fault_irq, line_break_irq}))
        else $error("rx flags moved while off");
    c_tx_req: cover property (tx_space_irq);
    c_break_req: cover property (line_break_irq);
    c_tx_push: cover property (acc && write && address[4:2] == 3'h2);
endmodule
bind fuc_uart fuc_uart_checker fuc_uart_checker_inst (.*);
`default_nettype wire

/* File: verification/fuc_station.sv */
// Remote serial station model, 8N1 at sixteen clocks a bit
`timescale 1ns/1ps
`default_nettype none
module fuc_station #(parameter int BIT = 16) (
    input wire logic clk, // Clock
    input wire logic txd, // From unit
    output logic rxd // To unit
);
    ////////////////////////////////////////
    logic [7:0] gotQ[$];
    initial rxd = 1'b1;
    // Stop bit given so a framing fault can be provoked
    task automatic send(input logic [7:0] d, input logic stopBit);
        logic [9:0] f;
        f = {stopBit, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rxd <= f[i];
            repeat (BIT) @(posedge clk);
        end
        rxd <= 1'b1;
        repeat (BIT) @(posedge clk);
    endtask
    // Samples mid-bit, clear of the unit's edges
    always begin
        logic [7:0] b;
        @(negedge txd);
        repeat (BIT / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge clk);
            b[i] = txd;
        end
        repeat (BIT) @(posedge clk);
        gotQ.push_back(b);
    end
endmodule
`default_nettype wire

/* File: verification/test_fifo_uart_control_enables.sv */
// Bench for the serial unit control enables
`timescale 1ns/1ps
`default_nettype none
`include "fuc_consts.svh"
module test_fifo_uart_control_enables;
    localparam logic [4:0] CTRL = {`FUC_IDX_CTRL, 2'b00};
    localparam logic [4:0] STAT = {`FUC_IDX_STAT, 2'b00};
    localparam logic [4:0] TXW = {`FUC_IDX_TXDATA, 2'b00};
    localparam logic [4:0] RXR = {`FUC_IDX_RXDATA, 2'b00};
    localparam logic [4:0] FCTL = {`FUC_IDX_FIFOCTL, 2'b00};
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [4:0] address = 5'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0000_0000;
    logic [31:0] readdata;
    logic waitrequest, rxd, txd, txIrq;
    logic [2:0] rxAll;
    logic [31:0] expQ[$], mskQ[$];
    logic [7:0] sentQ[$];
    int errTotal = 0;
    int cmpCount = 0;
    always #50 clk = ~clk;
    fuc_uart fuc_uart_inst (.clk, .reset_n, .address, .read, .write,
        .writedata, .byteenable(4'hF), .readdata, .waitrequest, .rxd, .txd,
        .tx_space_irq(txIrq), .rx_level_irq(rxAll[2]),
        .rx_fault_irq(rxAll[1]), .line_break_irq(rxAll[0]));
    fuc_station fuc_station_inst (.clk, .txd, .rxd);
    ////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] e, g);
        cmpCount++;
        if (g !== e) begin
            errTotal++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [4:0] a,
        input logic [31:0] d);
        @(posedge clk);
        read <= !w;
        write <= w;
        address <= a;
        writedata <= d;
        do @(posedge clk); while (waitrequest !== 1'b0);
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        bus(1'b1, a, {24'h00_0000, d});
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] e,
        input logic [31:0] m = 32'h0000_00FF);
        expQ.push_back(e & m);
        mskQ.push_back(m);
        bus(1'b0, a, 32'h0000_0000);
    endtask
    always @(posedge clk) begin
        if (read === 1'b1 && waitrequest === 1'b0) begin
            chk("readdata", expQ.pop_front(), readdata & mskQ.pop_front());
        end
    end
    task automatic endOfTest();
        $display("compares %0d mismatches %0d", cmpCount, errTotal);
        if (errTotal == 0 && cmpCount > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        #(100 * 20000);
        errTotal++;
        endOfTest();
    end
    ////////////////////////////////////////
    initial begin
        logic [7:0] b;
        b = $urandom(67079);
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        rd(CTRL, 32'h0000_0000);
        rd(5'h18, 32'h0000_0000, 32'hFFFF_FFFF);
        b = $urandom();
        wr(CTRL, b & 8'h0F);
        rd(CTRL, {24'h00_0000, b & 8'h03});
        $display("test reset done");
        bus(1'b1, FCTL, 32'h0002_0108);
        wr(CTRL, 8'h20);
        repeat (100) @(posedge clk);
        chk("txd", 1'b1, txd);
        wr(CTRL, 8'h00);
        for (int i = 0; i < 9; i++) begin
            b = $urandom();
            sentQ.push_back(b);
            wr(TXW, b);
        end
        rd(STAT, 32'h0000_0020, 32'h0000_0020);
        wr(STAT, 8'h00);
        wr(CTRL, 8'h80);
        @(negedge clk);
        chk("txIrq", 1'b0, txIrq);
        wr(CTRL, 8'hA0);
        for (int i = 0; i < 9; i++) begin
            wait (fuc_station_inst.gotQ.size() > 0);
            chk("line", sentQ.pop_front(), fuc_station_inst.gotQ.pop_front());
        end
        chk("txIrq", 1'b1, txIrq);
        wr(CTRL, 8'h20);
        @(negedge clk);
        chk("txIrq", 1'b0, txIrq);
        $display("test tx done");
        wr(CTRL, 8'h10);
        fuc_station_inst.send(8'h00, 1'b0);
        chk("rx irqs", 3'b000, rxAll);
        wr(CTRL, 8'h50);
        @(negedge clk);
        chk("rx irqs", 3'b111, rxAll);
        wr(CTRL, 8'h40);
        repeat (40) @(negedge clk);
        chk("rx irqs", 3'b111, rxAll);
        rd(RXR, 32'h0000_0000);
        rd(STAT, 32'h0000_009A, 32'h0000_009A);
        wr(STAT, 8'h00);
        @(negedge clk);
        chk("rx irqs", 3'b000, rxAll);
        fuc_station_inst.send(8'h5A, 1'b1);
        rd(RXR, 32'h0000_0000);
        wr(CTRL, 8'h50);
        b = $urandom();
        fuc_station_inst.send(b, 1'b1);
        rd(RXR, {24'h00_0000, b});
        wr(CTRL, 8'h10);
        @(negedge clk);
        chk("rxIrq", 1'b0, rxAll[2]);
        $display("test rx done");
        endOfTest();
    end
endmodule
`default_nettype wire
